// ==== hdl/adcc_pkg.sv ====
// Purpose: Shared constants, register map and types of the converter control block.
// Assumes: 32-bit classic Wishbone slave, byte addresses, one register per aligned word.
// Notes:   Only the low byte of each register is populated; upper bits read as zero.
`default_nettype none

package adcc_pkg;

    // Widths.
    localparam int ADR_W         = 8;
    localparam int DATA_W        = 32;
    localparam int SEL_W         = 4;
    localparam int RESULT_W      = 10;
    localparam int RESHI_W       = 8;
    localparam int RESLO_DATA_W  = 2;
    localparam int CHAN_W        = 3;
    localparam int PIN_W         = 7;
    localparam int IRQ_W         = 2;
    localparam int IDX_W         = 4;
    localparam int SAMPLE_CNT_W  = 8;

    // Register byte offsets.
    localparam logic [ADR_W-1:0] ADDR_CSR      = 8'h00;
    localparam logic [ADR_W-1:0] ADDR_RES_HI   = 8'h04;
    localparam logic [ADR_W-1:0] ADDR_RES_LO   = 8'h08;
    localparam logic [ADR_W-1:0] ADDR_PIN      = 8'h0C;
    localparam logic [ADR_W-1:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [ADR_W-1:0] ADDR_IRQ_MASK = 8'h14;

    // Field positions.
    localparam int CSR_CS_LSB     = 0;
    localparam int CSR_ON_BIT     = 5;
    localparam int CSR_EOC_BIT    = 7;
    localparam int RESLO_GAIN_BIT = 4;
    localparam int IRQ_EOC_BIT    = 0;
    localparam int IRQ_OVR_BIT    = 1;
    localparam int BYTE0_SEL      = 0;

    // Reset values and special codes.
    localparam logic [CHAN_W-1:0]   CHAN_RESET   = 3'h0;
    localparam logic [RESULT_W-1:0] RESULT_RESET = 10'h000;
    localparam logic [RESULT_W-1:0] RESULT_FULL  = 10'h3FF;
    localparam logic [IRQ_W-1:0]    IRQ_RESET    = 2'h0;

    // Timing: sampling phase length in clock cycles; each result bit takes two cycles.
    localparam int SAMPLE_CYCLES_DEF = 8;
    localparam int CYCLES_PER_BIT    = 2;

    typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_SET, SAR_TEST} adcc_sar_state_t;

    function automatic logic [RESULT_W-1:0] adcc_bit_mask(input logic [IDX_W-1:0] idx);
        return RESULT_W'(1) << idx;
    endfunction

endpackage

`default_nettype wire

// ==== hdl/adcc_sar.sv ====
// Purpose: Successive approximation sequencer: sample phase, then one trial per bit, MSB first.
// Assumes: cmp_above is high while the sampled input lies above the trial level on dac_code.
// Notes:   A comparator stuck high yields all ones, stuck low yields zero, so saturation
//          needs no extra logic and raises no overflow indication.
`default_nettype none

module adcc_sar #(
    parameter int SAMPLE_CYCLES = adcc_pkg::SAMPLE_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          reset_n,
    // Control
    input  wire logic                          start,
    input  wire logic                          abort,
    input  wire logic                          cmp_above,
    // Status and data
    output logic                               busy,
    output logic                               sample_hold,
    output logic                               done,
    output logic [adcc_pkg::RESULT_W-1:0]      dac_code,
    output logic [adcc_pkg::RESULT_W-1:0]      result
);
    import adcc_pkg::*;

    localparam logic [SAMPLE_CNT_W-1:0] SAMPLE_LAST = SAMPLE_CNT_W'(SAMPLE_CYCLES - 1);
    localparam logic [IDX_W-1:0]        MSB_IDX     = IDX_W'(RESULT_W - 1);

    adcc_sar_state_t           state_reg;
    logic [SAMPLE_CNT_W-1:0]   cnt_reg;
    logic [IDX_W-1:0]          idx_reg;
    logic [RESULT_W-1:0]       approx_reg;
    logic [RESULT_W-1:0]       dac_reg;
    logic [RESULT_W-1:0]       result_reg;
    logic                      done_reg;
    logic                      sample_reg;
    logic                      last_trial;

    assign last_trial  = (state_reg == SAR_TEST) && (idx_reg == '0);
    assign busy        = (state_reg != SAR_IDLE);
    assign sample_hold = sample_reg;
    assign done        = done_reg;
    assign dac_code    = dac_reg;
    assign result      = result_reg;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= SAR_IDLE;
            cnt_reg   <= '0;
            idx_reg   <= '0;
        end else if (abort) begin
            state_reg <= SAR_IDLE;
        end else begin
            unique case (state_reg)
                SAR_IDLE: begin
                    if (start) begin
                        state_reg <= SAR_SAMPLE;
                        cnt_reg   <= SAMPLE_LAST;
                    end
                end
                SAR_SAMPLE: begin
                    if (cnt_reg == '0) begin
                        state_reg <= SAR_SET;
                        idx_reg   <= MSB_IDX;
                    end else begin
                        cnt_reg <= cnt_reg - SAMPLE_CNT_W'(1);
                    end
                end
                SAR_SET: begin
                    state_reg <= SAR_TEST;
                end
                SAR_TEST: begin
                    if (idx_reg == '0) begin
                        state_reg <= SAR_IDLE;
                    end else begin
                        idx_reg   <= idx_reg - IDX_W'(1);
                        state_reg <= SAR_SET;
                    end
                end
            endcase
        end
    end

    // Trial level and kept bits.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            approx_reg <= RESULT_RESET;
            dac_reg    <= RESULT_RESET;
        end else if (state_reg == SAR_IDLE && start && !abort) begin
            approx_reg <= RESULT_RESET;
            dac_reg    <= RESULT_RESET;
        end else if (state_reg == SAR_SET) begin
            dac_reg <= approx_reg | adcc_bit_mask(idx_reg);
        end else if (state_reg == SAR_TEST && cmp_above) begin
            approx_reg <= dac_reg;
        end
    end

    // Completed result and one-cycle done pulse.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            result_reg <= RESULT_RESET;
            done_reg   <= 1'b0;
        end else begin
            done_reg <= last_trial && !abort;
            if (last_trial && !abort) begin
                result_reg <= cmp_above ? dac_reg : approx_reg;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sample_reg <= 1'b0;
        end else begin
            sample_reg <= !abort && ((state_reg == SAR_IDLE && start) ||
                                     (state_reg == SAR_SAMPLE && cnt_reg != '0));
        end
    end

endmodule // adcc_sar

`default_nettype wire

// ==== hdl/adcc_irq.sv ====
// Purpose: Sticky event status, write-one-to-clear, with a mask onto one level interrupt.
// Assumes: Event and clear strobes are single-cycle pulses in the clk_sys domain.
// Notes:   A set that meets a clear in the same cycle leaves the bit set.
`default_nettype none

module adcc_irq (
    // Clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        reset_n,
    // Events and software access
    input  wire logic [adcc_pkg::IRQ_W-1:0]  set_evt,
    input  wire logic [adcc_pkg::IRQ_W-1:0]  clr_w1c,
    input  wire logic                        mask_we,
    input  wire logic [adcc_pkg::IRQ_W-1:0]  mask_wdata,
    // State
    output logic [adcc_pkg::IRQ_W-1:0]       status,
    output logic [adcc_pkg::IRQ_W-1:0]       mask,
    output logic                             irq
);
    import adcc_pkg::*;

    logic [IRQ_W-1:0] status_reg;
    logic [IRQ_W-1:0] mask_reg;
    logic             irq_reg;

    assign status = status_reg;
    assign mask   = mask_reg;
    assign irq    = irq_reg;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            status_reg <= IRQ_RESET;
        end else begin
            status_reg <= (status_reg & ~clr_w1c) | set_evt;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mask_reg <= IRQ_RESET;
        end else if (mask_we) begin
            mask_reg <= mask_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(status_reg & mask_reg);
        end
    end

endmodule // adcc_irq

`default_nettype wire

// ==== hdl/adcc_top.sv ====
// Purpose: Control of a 10-bit successive approximation converter with seven inputs and a
//          x8 input amplifier, reached over a classic Wishbone slave.
// Assumes: Comparator, analog mux, amplifier and trial DAC sit outside; pins are synchronous.
// Notes:   Notes on behaviour are listed below; CPU wait has no effect, so no port exists.
//
// Notes on behaviour
// - Each conversion gives ten bits, held until the next conversion completes.
// - Three channel-select bits route one of seven inputs to the converter.
// - Setting converter-on powers up and starts converting; no separate start exists.
// - While converter-on stays set, conversions follow one another without end.
// - Every completed conversion sets the done flag and loads the new result.
// - Reading the high result clears the done flag; reading the low one does not.
// - Input above upper reference gives FFh high and 03h low, no overflow flag.
// - Input below lower reference gives zero in both result registers.
// - Gain-select bit in the low result register enables the x8 amplifier.
// - Amplifier powers with the converter, so selecting it adds no startup delay.
// - Clearing converter-on stops conversions and removes converter power.
// - CPU wait state leaves the converter running unchanged.
// - Halt disables the converter; software waits for stabilisation after wakeup.
// - Analog input pins remain readable as logic levels.
//
// Our own choices: the Wishbone register port and the register addresses.
`default_nettype none

module adcc_top #(
    parameter int SAMPLE_CYCLES = adcc_pkg::SAMPLE_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          reset_n,
    // Wishbone slave
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [adcc_pkg::ADR_W-1:0]    wb_adr_i,
    input  wire logic [adcc_pkg::SEL_W-1:0]    wb_sel_i,
    input  wire logic [adcc_pkg::DATA_W-1:0]   wb_dat_i,
    output logic [adcc_pkg::DATA_W-1:0]        wb_dat_o,
    output logic                               wb_ack_o,
    // Power state of the core
    input  wire logic                          cpu_halt,
    // Analog front end
    input  wire logic                          cmp_above,
    input  wire logic [adcc_pkg::PIN_W-1:0]    pin_level,
    output logic                               analog_power,
    output logic                               amp_enable,
    output logic [adcc_pkg::CHAN_W-1:0]        chan_sel,
    output logic                               sample_hold,
    output logic [adcc_pkg::RESULT_W-1:0]      dac_code,
    // Interrupt
    output logic                               irq
);
    import adcc_pkg::*;

    logic [DATA_W-1:0]   dat_o_reg;
    logic                ack_reg;
    logic [CHAN_W-1:0]   chan_reg;
    logic                on_reg;
    logic                gain_reg;
    logic                eoc_reg;
    logic [RESULT_W-1:0] result_reg;
    logic [PIN_W-1:0]    pin_level_reg;
    logic                start_reg;
    logic [CHAN_W-1:0]   chan_sel_reg;
    logic                analog_power_reg;
    logic                amp_enable_reg;

    logic                req;
    logic                wr_low;
    logic                rd;
    logic                rd_hi;
    logic                run;
    logic                start_next;
    logic                sar_busy;
    logic                sar_done;
    logic [RESULT_W-1:0] sar_result;
    logic [IRQ_W-1:0]    irq_status;
    logic [IRQ_W-1:0]    irq_mask;
    logic [IRQ_W-1:0]    irq_set;
    logic [IRQ_W-1:0]    irq_clr;
    logic [DATA_W-1:0]   rd_data;

    // One access is taken per request; ack lasts one cycle, so back-to-back strobes wait.
    assign req    = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr_low = req && wb_we_i && wb_sel_i[BYTE0_SEL];
    assign rd     = req && !wb_we_i;
    assign rd_hi  = rd && (wb_adr_i == ADDR_RES_HI);

    // Wait mode is not an input at all; only halt gates the converter.
    assign run        = on_reg && !cpu_halt;
    assign start_next = run && !sar_busy && !start_reg;

    assign wb_dat_o     = dat_o_reg;
    assign wb_ack_o     = ack_reg;
    assign analog_power = analog_power_reg;
    assign amp_enable   = amp_enable_reg;
    assign chan_sel     = chan_sel_reg;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end

    always_comb begin
        rd_data = '0;
        case (wb_adr_i)
            ADDR_CSR: begin
                rd_data[CSR_CS_LSB +: CHAN_W] = chan_reg;
                rd_data[CSR_ON_BIT]           = on_reg;
                rd_data[CSR_EOC_BIT]          = eoc_reg;
            end
            ADDR_RES_HI:   rd_data[RESHI_W-1:0] = result_reg[RESULT_W-1 -: RESHI_W];
            ADDR_RES_LO: begin
                rd_data[RESLO_DATA_W-1:0] = result_reg[RESLO_DATA_W-1:0];
                rd_data[RESLO_GAIN_BIT]   = gain_reg;
            end
            ADDR_PIN:      rd_data[PIN_W-1:0] = pin_level_reg;
            ADDR_IRQ_STAT: rd_data[IRQ_W-1:0] = irq_status;
            ADDR_IRQ_MASK: rd_data[IRQ_W-1:0] = irq_mask;
            default:       rd_data = '0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dat_o_reg <= '0;
        end else if (rd) begin
            dat_o_reg <= rd_data;
        end
    end

    // Software controls; all clear on reset.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            chan_reg <= CHAN_RESET;
            on_reg   <= 1'b0;
            gain_reg <= 1'b0;
        end else if (wr_low && wb_adr_i == ADDR_CSR) begin
            chan_reg <= wb_dat_i[CSR_CS_LSB +: CHAN_W];
            on_reg   <= wb_dat_i[CSR_ON_BIT];
        end else if (wr_low && wb_adr_i == ADDR_RES_LO) begin
            gain_reg <= wb_dat_i[RESLO_GAIN_BIT];
        end
    end

    // Done flag: a completion in the same cycle as the clearing read keeps it set.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            eoc_reg <= 1'b0;
        end else if (sar_done) begin
            eoc_reg <= 1'b1;
        end else if (rd_hi) begin
            eoc_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            result_reg <= RESULT_RESET;
        end else if (sar_done) begin
            result_reg <= sar_result;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pin_level_reg <= '0;
        end else begin
            pin_level_reg <= pin_level;
        end
    end

    // The mux is latched per conversion so a channel change never splits one result.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            start_reg    <= 1'b0;
            chan_sel_reg <= CHAN_RESET;
        end else begin
            start_reg <= start_next;
            if (start_next) begin
                chan_sel_reg <= chan_reg;
            end
        end
    end

    // Amplifier shares the converter's power, so it needs no warm-up of its own.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            analog_power_reg <= 1'b0;
            amp_enable_reg   <= 1'b0;
        end else begin
            analog_power_reg <= run;
            amp_enable_reg   <= run && gain_reg;
        end
    end

    adcc_sar #(
        .SAMPLE_CYCLES (SAMPLE_CYCLES)
    ) u_sar (
        .clk_sys     (clk_sys),
        .reset_n     (reset_n),
        .start       (start_reg),
        .abort       (!run),
        .cmp_above   (cmp_above),
        .busy        (sar_busy),
        .sample_hold (sample_hold),
        .done        (sar_done),
        .dac_code    (dac_code),
        .result      (sar_result)
    );

    // Overrun marks a result that replaced one software never collected.
    assign irq_set[IRQ_EOC_BIT] = sar_done;
    assign irq_set[IRQ_OVR_BIT] = sar_done && eoc_reg && !rd_hi;
    assign irq_clr = (wr_low && wb_adr_i == ADDR_IRQ_STAT) ? wb_dat_i[IRQ_W-1:0] : IRQ_RESET;

    adcc_irq u_irq (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .set_evt    (irq_set),
        .clr_w1c    (irq_clr),
        .mask_we    (wr_low && wb_adr_i == ADDR_IRQ_MASK),
        .mask_wdata (wb_dat_i[IRQ_W-1:0]),
        .status     (irq_status),
        .mask       (irq_mask),
        .irq        (irq)
    );

    // Checking helpers: cycles since the last start, and comparator history per conversion.
    // Nine bits so that the longest sample phase still fits the age count.
    localparam int CONV_CYCLES = SAMPLE_CYCLES + CYCLES_PER_BIT * RESULT_W + 1;
    logic [8:0] conv_age_reg;
    logic       all_hi_reg;
    logic       all_lo_reg;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            conv_age_reg <= '0;
            all_hi_reg   <= 1'b0;
            all_lo_reg   <= 1'b0;
        end else if (start_reg) begin
            conv_age_reg <= 9'h001;
            all_hi_reg   <= 1'b1;
            all_lo_reg   <= 1'b1;
        end else begin
            if (conv_age_reg != 9'h1FF) begin
                conv_age_reg <= conv_age_reg + 9'h001;
            end
            // A zero trial level is met by any input, so only real trials are counted.
            if (dac_code != RESULT_RESET) begin
                all_hi_reg <= all_hi_reg && cmp_above;
                all_lo_reg <= all_lo_reg && !cmp_above;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence s_done_running;
        sar_done && run;
    endsequence

    sequence s_switch_on;
        $rose(on_reg) && !cpu_halt && !sar_busy;
    endsequence

    a_result_hold: assert property (!sar_done |=> $stable(result_reg))
        else $error("result changed without a completed conversion");
    a_chan_route: assert property (start_next |=> chan_sel_reg == $past(chan_reg))
        else $error("mux not routed to the selected channel");
    a_on_starts: assert property (s_switch_on |=> start_reg ##1 sar_busy)
        else $error("converter-on did not start a conversion");
    a_conv_restart: assert property (s_done_running |=> start_reg)
        else $error("continuous conversion did not restart");
    a_done_loads: assert property (sar_done |=> eoc_reg && result_reg == $past(sar_result))
        else $error("completion did not set flag and result");
    a_hi_read_clears: assert property (rd_hi && !sar_done |=> !eoc_reg)
        else $error("high result read did not clear done flag");
    a_lo_read_keeps: assert property (rd && wb_adr_i == ADDR_RES_LO && eoc_reg |=> eoc_reg)
        else $error("low result read cleared done flag");
    a_sat_high: assert property (sar_done && all_hi_reg && cmp_above |=> result_reg == RESULT_FULL)
        else $error("over-range input did not saturate at full scale");
    a_sat_low: assert property (sar_done && all_lo_reg && !cmp_above |=> result_reg == RESULT_RESET)
        else $error("under-range input did not give zero");
    a_amp_power: assert property (run && gain_reg |=> amp_enable_reg && analog_power_reg)
        else $error("amplifier not enabled with the converter");
    a_off_stops: assert property (!run |=> !sar_busy && !analog_power_reg && !start_reg)
        else $error("converter still active while off or halted");
    a_pin_read: assert property (rd && wb_adr_i == ADDR_PIN |=> wb_dat_o[PIN_W-1:0] == $past(pin_level_reg))
        else $error("pin level not returned on read");
    a_conv_length: assert property (sar_done |-> conv_age_reg == 9'(CONV_CYCLES))
        else $error("conversion length differs from the fixed count");

endmodule // adcc_top

`default_nettype wire

// ==== dv/adcc_front_model.sv ====
// Purpose: Comparator and channel levels standing in for the analog front end.
// Assumes: Fixed input level per channel, compared against the trial level at once.
// Notes:   With power off the comparator never fires.
`default_nettype none
module adcc_front_model (
    // Converter side
    input  wire logic                          analog_power,
    input  wire logic                          amp_enable,
    input  wire logic [adcc_pkg::CHAN_W-1:0]   chan_sel,
    input  wire logic [adcc_pkg::RESULT_W-1:0] dac_code,
    // Decision
    output logic                               cmp_above
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [13:0] level;
    always_comb begin
        case (chan_sel)
            3'h5: level = 14'h02A7;
            3'h6: level = 14'h07FF;
            3'h1: level = 14'h0040;
            default: level = 14'h0000;
        endcase
        if (amp_enable) level = level << 3;
    end
    // Levels beyond either reference keep every trial bit or none of them.
    assign cmp_above = analog_power && (level >= 14'(dac_code));
endmodule // adcc_front_model
`default_nettype wire

// ==== dv/adc_conversion_control_tb_top.sv ====
// Purpose: Register-level regression of the converter control block.
// Assumes: The front-end model supplies a fixed level per channel.
// Notes:   A two-cycle sample phase keeps each conversion short.
`default_nettype none
module adc_conversion_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import adcc_pkg::*;
    logic        clk_sys = 0, reset_n = 0, cyc = 0, stb = 0, we = 0, cpu_halt = 0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000, rdat, q;
    logic        ack, irq, pw, amp, sh, cmp;
    logic [2:0]  chan;
    logic [9:0]  dac;
    logic [6:0]  pins = 7'h5A;
    logic [7:0]  chans [3] = '{8'h05, 8'h06, 8'h00};
    logic [7:0]  ehi [3] = '{8'hA9, 8'hFF, 8'h00};
    logic [7:0]  elo [3] = '{8'h03, 8'h03, 8'h00};
    int          failures = 0, total_checks = 0, cycles = 0;
    adcc_top #(.SAMPLE_CYCLES(2)) u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .cpu_halt(cpu_halt),
        .cmp_above(cmp), .pin_level(pins), .analog_power(pw), .amp_enable(amp),
        .chan_sel(chan), .sample_hold(sh), .dac_code(dac), .irq(irq));
    adcc_front_model u_fe (.analog_power(pw), .amp_enable(amp), .chan_sel(chan),
        .dac_code(dac), .cmp_above(cmp));
    initial forever #4 clk_sys = ~clk_sys;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // Request held until ack is sampled high; data taken at that same edge.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {cyc, stb, we, sel, adr, wdat} <= {1'b1, 1'b1, w, 4'h1, a, d};
        do @(posedge clk_sys); while (ack !== 1'b1);
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        q = 32'h0000_0000;
        while (q[7] !== 1'b1 && n < 300) begin
            wb(0, ADDR_CSR, 32'h0000_0000);
            n++;
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            results();
        end
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        reset_n <= 1;
        wb(0, ADDR_CSR, 0); chk("csr reset", 0, q);
        wb(0, ADDR_PIN, 0); chk("pins", 32'(pins), q);
        wb(1, ADDR_IRQ_MASK, 8'h01);
        for (int i = 0; i < 3; i++) begin
            wb(1, ADDR_CSR, chans[i]);
            wb(0, ADDR_RES_HI, 0);
            wb(1, ADDR_CSR, chans[i] | 8'h20);
            @(posedge clk_sys); chk("power", 1, pw);
            @(posedge clk_sys); chk("sample hold", 1, sh);
            wait_done(); chk("done", 1, q[7]);
            chk("chan_sel", chans[i], chan);
            wb(0, ADDR_RES_LO, 0); chk("res_lo", elo[i], q);
            wb(0, ADDR_CSR, 0); chk("done after lo", 1, q[7]);
            wb(0, ADDR_RES_HI, 0); chk("res_hi", ehi[i], q);
            wb(0, ADDR_CSR, 0); chk("done after hi", 0, q[7]);
            $display("test channel %0d done", chans[i]);
        end
        wait_done(); chk("continuous", 1, q[7]);
        chk("irq", 1, irq);
        wb(1, ADDR_CSR, 0);
        @(posedge clk_sys); chk("power off", 0, pw);
        wb(1, ADDR_IRQ_STAT, 8'h03);
        wb(0, ADDR_IRQ_STAT, 0); chk("irq stat", 0, q);
        chk("irq low", 0, irq);
        wb(1, ADDR_RES_LO, 8'h10);
        wb(1, ADDR_CSR, 8'h21);
        @(posedge clk_sys); chk("amp", 1, amp);
        wb(0, ADDR_RES_HI, 0);
        wait_done();
        wb(0, ADDR_RES_HI, 0); chk("gain hi", 8'h80, q);
        cpu_halt <= 1;
        repeat (3) @(posedge clk_sys);
        chk("halt power", 0, pw);
        cpu_halt <= 0;
        $display("test power modes done");
        results();
    end
endmodule // adc_conversion_control_tb_top
`default_nettype wire
